// ### include/hlbt_pkg.sv
/*
 * constants for the single-wire host link bit timing block: times in their own
 * units and the cycle counts derived from them at the 100 MHz reference clock.
 * assumes nothing of its surroundings.
 */
package hlbt_pkg;
	localparam int CLK_MHZ         = 100;       // reference clock rate
	localparam int BREAK_MIN_US    = 190;       // least host break low time
	localparam int HW1_MAX_US      = 50;        // longest host write-one pulse
	localparam int HW0_MIN_US      = 86;        // least host write-zero pulse
	localparam int SAMPLE_US       = 68;        // host bit sample point
	localparam int SLOT_NOM_US     = 205;       // nominal device bit slot
	localparam int DW1_US          = 41;        // device write-one low time
	localparam int DW0_US          = 112;       // device write-zero low time
	localparam int RESP_MIN_US     = 190;       // least response gap
	localparam int DW1_MIN_US      = 32;        // device write-one low, lower bound
	localparam int DW1_MAX_US      = 50;        // device write-one low, upper bound
	localparam int DW0_MIN_US      = 80;        // device write-zero low, lower bound
	localparam int DW0_MAX_US      = 145;       // device write-zero low, upper bound
	localparam int SLOT_MIN_US     = 190;       // device bit slot, lower bound
	localparam int SLOT_MAX_US     = 250;       // device bit slot, upper bound
	localparam int RST_MIN_MS      = 1900;      // bus reset window, lower bound
	localparam int SAMPLE_CYC      = SAMPLE_US * CLK_MHZ;
	localparam int BREAK_CYC       = BREAK_MIN_US * CLK_MHZ;
	localparam int SLOT_CYC        = SLOT_NOM_US * CLK_MHZ;
	localparam int DW1_CYC         = DW1_US * CLK_MHZ;
	localparam int DW0_CYC         = DW0_US * CLK_MHZ;
	localparam int RESP_CYC        = RESP_MIN_US * CLK_MHZ;
	localparam int RST_CYC         = RST_MIN_MS * 1000 * CLK_MHZ; // 190,000,000
	localparam int CNT_W           = 28;        // wide enough for the reset count
	localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// ### rtl/hlbt_top.sv
/*
 * bit-level timing of the single-wire host link plus bus-stuck timeouts of the
 * two-wire and four-wire ports. assumes a pulled-up open-drain line outside,
 * inputs synchronous to ref_clk_i, and an upper layer that supplies reply bytes.
 */
// Function
// R1 - host breaks 190us low, recovers 40us
// R2 - host one pulse 0.5 to 50us
// R3 - host zero pulse 86 to 145us
// R4 - host bit slot at least 190us
// R5 - device slot 190 to 250us, nominal 205
// R6 - device one low 32 to 50us
// R7 - device zero low 80 to 145us
// R8 - response gap at least 190us
// R9 - host turnaround at least 210us
// R10 - long line low resets link logic
// R11 - two-wire clock stuck low resets port
// R12 - two-wire clock at most 400kHz
// R13 - four-wire clock period at least 500ns
// R14 - four-wire transfers spaced, device needs 50us
// R15 - select low, clock frozen resets port
// R16 - host bits sampled at fixed point
// R17 - bytes least significant bit first
`timescale 1ns/1ps
module hlbt_top #(
	parameter int CLK_MHZ  = hlbt_pkg::CLK_MHZ,
	parameter int RST_CYC  = hlbt_pkg::RST_CYC,
	parameter int RESP_CYC = hlbt_pkg::RESP_CYC,
	parameter int BREAK_CYC = hlbt_pkg::BREAK_CYC
) (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       single_wire_host_line_i,  // line level
	output logic            single_wire_host_line_o,  // always low when driven
	output logic            single_wire_host_line_oe_o,
	input  wire logic       tx_valid_i,               // reply byte ready
	input  wire logic [7:0] tx_byte_i,
	output logic            tx_taken_o,               // pulse: reply byte accepted
	output logic            rx_valid_o,               // pulse: host byte received
	output logic [7:0]      rx_byte_o,
	output logic            break_seen_o,             // pulse: break detected
	output logic            link_reset_o,             // pulse: single-wire reset
	input  wire logic       i2c_scl_i,
	output logic            i2c_reset_o,              // pulse: two-wire reset
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_sclk_i,
	output logic            spi_reset_o               // pulse: four-wire reset
);
	typedef enum {ST_IDLE, ST_LOW, ST_WAIT_RISE, ST_RESP, ST_TX_LOW, ST_TX_REST} hlbt_state_t;
	localparam int CW = hlbt_pkg::CNT_W;
	// bit timing in reference clock cycles
	localparam int SAMPLE_CYC   = hlbt_pkg::SAMPLE_US * CLK_MHZ;
	localparam int SLOT_CYC     = hlbt_pkg::SLOT_NOM_US * CLK_MHZ;
	localparam int DW1_CYC      = hlbt_pkg::DW1_US * CLK_MHZ;
	localparam int DW0_CYC      = hlbt_pkg::DW0_US * CLK_MHZ;
	localparam int DW1_MIN_CYC  = hlbt_pkg::DW1_MIN_US * CLK_MHZ;
	localparam int DW1_MAX_CYC  = hlbt_pkg::DW1_MAX_US * CLK_MHZ;
	localparam int DW0_MIN_CYC  = hlbt_pkg::DW0_MIN_US * CLK_MHZ;
	localparam int DW0_MAX_CYC  = hlbt_pkg::DW0_MAX_US * CLK_MHZ;
	localparam int SLOT_MIN_CYC = hlbt_pkg::SLOT_MIN_US * CLK_MHZ;
	localparam int SLOT_MAX_CYC = hlbt_pkg::SLOT_MAX_US * CLK_MHZ;

	hlbt_state_t     state_reg;
	logic [CW-1:0]   cnt_reg;
	logic [CW-1:0]   low_cnt_reg;
	logic [CW-1:0]   scl_cnt_reg;
	logic [CW-1:0]   spi_cnt_reg;
	logic            line_d_reg;
	logic            sclk_d_reg;
	logic [2:0]      bit_idx_reg;
	logic [7:0]      shift_reg;
	logic            fell;

	assign fell = line_d_reg && !single_wire_host_line_i;

	////////////////////////////////////////////////////////////////////////////
	// edge history of the line and serial clock
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
		begin
			line_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
		end
		else
		begin
			line_d_reg <= single_wire_host_line_i;
			sclk_d_reg <= spi_sclk_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// single-wire long-low timeout
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || single_wire_host_line_i)
			low_cnt_reg <= '0;
		else if (low_cnt_reg != CW'(RST_CYC))
			low_cnt_reg <= low_cnt_reg + 1'b1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			link_reset_o <= 1'b0;
		else
			link_reset_o <= (low_cnt_reg == CW'(RST_CYC - 1)); // [R10]
	end

	////////////////////////////////////////////////////////////////////////////
	// two-wire clock stuck low timeout
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || i2c_scl_i)
			scl_cnt_reg <= '0;
		else if (scl_cnt_reg != CW'(RST_CYC))
			scl_cnt_reg <= scl_cnt_reg + 1'b1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			i2c_reset_o <= 1'b0;
		else
			i2c_reset_o <= (scl_cnt_reg == CW'(RST_CYC - 1)); // [R11]
	end

	////////////////////////////////////////////////////////////////////////////
	// four-wire frozen clock under select timeout
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || spi_cs_n_i || (spi_sclk_i != sclk_d_reg))
			spi_cnt_reg <= '0;
		else if (spi_cnt_reg != CW'(RST_CYC))
			spi_cnt_reg <= spi_cnt_reg + 1'b1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			spi_reset_o <= 1'b0;
		else
			spi_reset_o <= (spi_cnt_reg == CW'(RST_CYC - 1)); // [R15]
	end

	////////////////////////////////////////////////////////////////////////////
	// single-wire bit engine: receive, response gap, transmit
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || link_reset_o)
		begin
			state_reg                  <= ST_IDLE;
			cnt_reg                    <= '0;
			bit_idx_reg                <= 3'h0;
			shift_reg                  <= hlbt_pkg::BYTE_RESET;
			rx_valid_o                 <= 1'b0;
			rx_byte_o                  <= hlbt_pkg::BYTE_RESET;
			tx_taken_o                 <= 1'b0;
			break_seen_o               <= 1'b0;
			single_wire_host_line_o    <= 1'b0;
			single_wire_host_line_oe_o <= 1'b0;
		end
		else
		begin
			rx_valid_o   <= 1'b0;
			tx_taken_o   <= 1'b0;
			break_seen_o <= 1'b0;
			cnt_reg      <= cnt_reg + 1'b1;
			case (state_reg)
				ST_IDLE:
				begin
					if (fell)
					begin
						state_reg <= ST_LOW;
						cnt_reg   <= CW'(1);
					end
				end
				ST_LOW:
				begin
					// one fixed sample point splits short and long pulses
					if (cnt_reg == CW'(SAMPLE_CYC)) // [R16]
					begin
						shift_reg <= {single_wire_host_line_i, shift_reg[7:1]}; // [R17]
						bit_idx_reg <= bit_idx_reg + 1'b1;
						if (bit_idx_reg == 3'h7)
						begin
							rx_valid_o <= 1'b1;
							rx_byte_o  <= {single_wire_host_line_i, shift_reg[7:1]};
						end
					end
					// a short one pulse has risen already: stay until the sample is taken
					if (single_wire_host_line_i && cnt_reg > CW'(SAMPLE_CYC))
					begin
						if (cnt_reg >= CW'(BREAK_CYC)) // [R1]
						begin
							break_seen_o <= 1'b1;
							bit_idx_reg  <= 3'h0;
							state_reg    <= ST_IDLE;
						end
						else if (tx_valid_i && bit_idx_reg == 3'h0)
						begin
							state_reg <= ST_RESP;
							cnt_reg   <= '0;
						end
						else
							state_reg <= ST_IDLE;
					end
				end
				ST_RESP:
				begin
					if (fell)
					begin
						state_reg <= ST_LOW;
						cnt_reg   <= CW'(1);
					end
					else if (cnt_reg == CW'(RESP_CYC)) // [R8]
					begin
						shift_reg   <= tx_byte_i;
						tx_taken_o  <= 1'b1;
						bit_idx_reg <= 3'h0;
						state_reg   <= ST_TX_LOW;
						cnt_reg     <= '0;
						single_wire_host_line_oe_o <= 1'b1;
					end
				end
				ST_TX_LOW:
				begin
					// low time picks the bit value
					if (cnt_reg == (shift_reg[0] ? CW'(DW1_CYC)
						: CW'(DW0_CYC)) - 1'b1) // [R6] [R7]
					begin
						single_wire_host_line_oe_o <= 1'b0;
						state_reg <= ST_TX_REST;
					end
				end
				ST_TX_REST:
				begin
					if (cnt_reg == CW'(SLOT_CYC - 1)) // [R5]
					begin
						shift_reg   <= {1'b0, shift_reg[7:1]}; // [R17]
						bit_idx_reg <= bit_idx_reg + 1'b1;
						cnt_reg     <= '0;
						if (bit_idx_reg == 3'h7)
							state_reg <= ST_IDLE;
						else
						begin
							state_reg <= ST_TX_LOW;
							single_wire_host_line_oe_o <= 1'b1;
						end
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// helper counters for the transmit timing checks
	logic [CW-1:0]   oe_run_reg;
	logic [CW-1:0]   slot_run_reg;

	// cycles the device has held the line low so far
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i || !single_wire_host_line_oe_o)
			oe_run_reg <= '0;
		else if (oe_run_reg != '1)
			oe_run_reg <= oe_run_reg + 1'b1;
	end

	// cycles since the device last started a slot
	always_ff @(posedge ref_clk_i)
	begin
		if (!reset_n_i)
			slot_run_reg <= '0;
		else if (single_wire_host_line_oe_o && oe_run_reg == '0)
			slot_run_reg <= CW'(1);
		else if (slot_run_reg != '1)
			slot_run_reg <= slot_run_reg + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	chk_one_low_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R6]
		$fell(single_wire_host_line_oe_o) && shift_reg[0] |->
		oe_run_reg >= CW'(DW1_MIN_CYC) && oe_run_reg <= CW'(DW1_MAX_CYC))
		else $error("one bit low time wrong");
	chk_zero_low_time: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R7]
		$fell(single_wire_host_line_oe_o) && !shift_reg[0] |->
		oe_run_reg >= CW'(DW0_MIN_CYC) && oe_run_reg <= CW'(DW0_MAX_CYC))
		else $error("zero bit low time wrong");
	chk_slot_len: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R5]
		single_wire_host_line_oe_o && oe_run_reg == '0 && bit_idx_reg != 3'h0 |->
		slot_run_reg >= CW'(SLOT_MIN_CYC) && slot_run_reg <= CW'(SLOT_MAX_CYC))
		else $error("device slot out of range");
	chk_link_rst: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R10]
		link_reset_o |-> $past(!single_wire_host_line_i))
		else $error("link reset without low line");
	chk_i2c_rst: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R11]
		i2c_reset_o |-> $past(!i2c_scl_i))
		else $error("two-wire reset without low clock");
	chk_spi_rst: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R15]
		spi_reset_o |-> $past(!spi_cs_n_i))
		else $error("four-wire reset without select");
	chk_resp_gap: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R8]
		tx_taken_o |-> $past(state_reg) == ST_RESP)
		else $error("reply without response gap");
	chk_no_drive_rx: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R16]
		state_reg == ST_LOW |-> !single_wire_host_line_oe_o)
		else $error("driving while receiving");
	chk_single_pulse: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // receive strobe lasts one cycle
		rx_valid_o |=> !rx_valid_o)
		else $error("receive strobe too long");
	cov_rx_byte: cover property (@(posedge ref_clk_i) rx_valid_o);
	cov_tx_byte: cover property (@(posedge ref_clk_i) tx_taken_o);
	cov_break:   cover property (@(posedge ref_clk_i) break_seen_o);
endmodule // hlbt_top

// ### tb/hlbt_host_model.sv
/* host end of the single-wire link: break, bit writes, reply decode.
   assumes the pulled-up line is resolved outside and US clock cycles per microsecond of link time. */
`timescale 1ns/1ps
module hlbt_host_model #(
	parameter int US = 10 // clock cycles per microsecond of link time
) (
	input  wire logic ref_clk_i,
	input  wire logic line_i,
	output logic      host_oe_o
);
	initial host_oe_o = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// pull low for lo cycles, then release for hi cycles
	task automatic pulse(input int lo, input int hi);
		host_oe_o = 1'b1;
		repeat (lo) @(posedge ref_clk_i);
		#1 host_oe_o = 1'b0;
		repeat (hi) @(posedge ref_clk_i);
		#1;
	endtask
	// break and recovery, then eight slots lsb first
	task automatic send_byte(input logic [7:0] b);
		pulse(191 * US, 41 * US);
		for (int i = 0; i < 8; i++)
			pulse(b[i] ? 20 * US : 100 * US,
				i == 7 ? 1 : (b[i] ? 175 * US : 95 * US));
	endtask
	// time each returned slot, decode it by its low width, then turn around
	task automatic recv_byte(output logic [7:0] b, output int bad);
		int t;
		int lo;
		bad = 0;
		lo = 0;
		for (int i = 0; i < 8; i++)
		begin
			t = 0;
			while (line_i === 1'b1 && t < 400 * US) @(posedge ref_clk_i) t++;
			if (i == 0 ? t + 1 < 190 * US : (lo + t < 190 * US || lo + t > 250 * US))
				bad++;
			lo = 0;
			while (line_i === 1'b0 && lo < 200 * US) @(posedge ref_clk_i) lo++;
			b[i] = lo < 76 * US;
			if (!(lo inside {[32 * US:50 * US], [80 * US:145 * US]}))
				bad++;
		end
		repeat (210 * US) @(posedge ref_clk_i);
		#1;
	endtask
endmodule // hlbt_host_model

// ### tb/testbench.sv
/* bench for the host link timing block: one exchange on the single-wire line
   and the three stuck-bus timeouts. assumes the host model beside it. */
`timescale 1ns/1ps
module testbench;
	logic       ref_clk_i, reset_n_i, line, host_oe, dut_o, dut_oe, tx_valid, tx_taken;
	logic       rx_valid, brk, lrst, scl, irst, cs_n, sclk, srst;
	logic [7:0] tx_byte, rx_byte, got;
	int         error_cnt, check_count, bad, n_rx, n_tx, n_brk, n_lrst, n_irst, n_srst;
	////////////////////////////////////////////////////////////////////////////////
	// open-drain line with pull-up
	assign line = ~(host_oe | (dut_oe & ~dut_o));
	// link time scaled to 10 cycles per microsecond to keep the run short
	hlbt_top #(.CLK_MHZ(10), .RST_CYC(3000), .RESP_CYC(1900), .BREAK_CYC(1900)) DUT (
		.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .single_wire_host_line_i(line),
		.single_wire_host_line_o(dut_o), .single_wire_host_line_oe_o(dut_oe),
		.tx_valid_i(tx_valid), .tx_byte_i(tx_byte), .tx_taken_o(tx_taken),
		.rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .break_seen_o(brk),
		.link_reset_o(lrst), .i2c_scl_i(scl), .i2c_reset_o(irst),
		.spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_reset_o(srst));
	hlbt_host_model #(.US(10)) host (.ref_clk_i(ref_clk_i), .line_i(line),
		.host_oe_o(host_oe));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// tally the one-cycle pulses
	always @(posedge ref_clk_i)
	begin
		n_rx += rx_valid;
		n_tx += tx_taken;
		n_brk += brk;
		n_lrst += lrst;
		n_irst += irst;
		n_srst += srst;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", name, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// host byte followed by a queued reply
	task automatic t_exchange;
		tx_byte = 8'h3C;
		tx_valid = 1'b1;
		host.send_byte(8'hA5);
		host.recv_byte(got, bad);
		tx_valid = 1'b0;
		chk("rx_byte", 8'hA5, rx_byte);
		chk("rx_count", 1, n_rx);
		chk("break_count", 1, n_brk);
		chk("taken_count", 1, n_tx);
		chk("reply_byte", 8'h3C, got);
		chk("reply_timing", 0, bad);
		chk("link_reset_count", 0, n_lrst);
	endtask
	// line held low past the reset count
	task automatic t_line_reset;
		host.pulse(3100, 100);
		chk("link_reset_count", 1, n_lrst);
	endtask
	// clock low short of the reset count, released briefly, then stuck low
	task automatic t_i2c;
		scl = 1'b0;
		hold(2000);
		scl = 1'b1;
		hold(10);
		scl = 1'b0;
		hold(2000);
		chk("i2c_reset_count", 0, n_irst);
		hold(1100);
		chk("i2c_reset_count", 1, n_irst);
		scl = 1'b1;
	endtask
	// select held while the clock moves, then frozen
	task automatic t_spi;
		chk("spi_reset_count", 0, n_srst);
		cs_n = 1'b0;
		repeat (2)
		begin
			hold(2000);
			sclk = ~sclk;
		end
		chk("spi_reset_count", 0, n_srst);
		hold(3100);
		chk("spi_reset_count", 1, n_srst);
		cs_n = 1'b1;
		hold(500);
	endtask
	// reset, then the scenarios in turn
	initial
	begin
		reset_n_i = 1'b0;
		tx_valid = 1'b0;
		tx_byte = 8'h00;
		scl = 1'b1;
		cs_n = 1'b1;
		sclk = 1'b0;
		hold(8);
		reset_n_i = 1'b1;
		hold(2);
		t_exchange();
		t_line_reset();
		t_i2c();
		t_spi();
		end_sim();
	end
endmodule // testbench
